/* File: common/adcrh_defines.svh */
// constants for the conversion result hand-off and calibration block
`ifndef ADCRH_DEFINES_SVH
`define ADCRH_DEFINES_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define ADCRH_CLK_PERIOD_NS     100
`define ADCRH_RESULT_READY_N_MIN_HIGH_NS  400
`define ADCRH_RESULT_READY_N_MIN_HIGH_CYC ((`ADCRH_RESULT_READY_N_MIN_HIGH_NS + `ADCRH_CLK_PERIOD_NS - 1) / `ADCRH_CLK_PERIOD_NS)
`define ADCRH_OSC_PER_CODE      512
`define ADCRH_START_MARGIN      128
`define ADCRH_FINISH_MARGIN     1440
// ----------------------------------------
// control register fields
// ----------------------------------------
`define ADCRH_CTL_SDL    0
`define ADCRH_CTL_MSBF   1
`define ADCRH_CTL_BD     2
`define ADCRH_CTL_SB     3
`define ADCRH_CTL_BO     4
`define ADCRH_CTL_G_LO   5
`define ADCRH_CTL_BU     8
`define ADCRH_CTL_MD_LO  9
`define ADCRH_CTL_MD_HI  11
`define ADCRH_CTL_FP_LO  12
`define ADCRH_CTL_FP_HI  22
`define ADCRH_CTL_DC     23
`define ADCRH_CTL_RESET  24'h014100
`define ADCRH_CAL_MD_MIN 3'h1
`define ADCRH_CAL_MD_MAX 3'h5
// ----------------------------------------
// calibration reset values and unity gain
// ----------------------------------------
`define ADCRH_OFF_RESET  24'h000000
`define ADCRH_POS_RESET  24'h400000
`define ADCRH_NEG_RESET  24'h400000
`define ADCRH_GAIN_SHIFT 22
`endif

/* File: common/adcrh_pkg.sv */
// types for the conversion result hand-off and calibration block
`default_nettype none
package adcrh_pkg;
   // register selected by the serial framing logic
   typedef enum logic [2:0]
   {
      ADCRH_SEL_DATA = 3'h0,
      ADCRH_SEL_CTL  = 3'h1,
      ADCRH_SEL_OFF  = 3'h2,
      ADCRH_SEL_POS  = 3'h3,
      ADCRH_SEL_NEG  = 3'h4
   } adcrh_sel_t;
   typedef logic [23:0] adcrh_word_t;
endpackage
`default_nettype wire

/* File: hw/adcrh_result_cal.sv */
// result hand-off, ready line, control and calibration registers
`default_nettype none
`include "adcrh_defines.svh"
// Function
// [RULE_01] drive ready low while word waits
// [RULE_02] read in progress keeps word intact
// [RULE_03] one word holding buffer beside output
// [RULE_04] host starts read within window
// [RULE_05] late finish: newer word replaces buffer
// [RULE_06] completed read drives ready high
// [RULE_07] buffered word moves, ready after high
// [RULE_08] upper control writes: ready high, recal
// [RULE_09] byte 0 write alone: no effect
// [RULE_10] host rewrites all bytes on gain
// [RULE_11] offset register loads self-cal value
// [RULE_12] offset makes zero input read zero
// [RULE_13] positive slope coefficient register
// [RULE_14] negative slope coefficient register
// [RULE_15] standby halts filter, ready high
// [RULE_16] byte order bit picks access order
// [RULE_17] oscillator counters track read windows
module adcrh_result_cal
(
   // clock and reset
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_b,
   // serial clock pin
   input  wire logic                 i_sclk,
   // register access from serial framing
   input  wire adcrh_pkg::adcrh_sel_t i_reg_sel,
   input  wire logic                 i_data_rd_active,
   input  wire logic                 i_rd_done,
   input  wire logic [1:0]           i_byte_idx,
   input  wire logic                 i_wr,
   input  wire logic [7:0]           i_wr_data,
   // filter and calibration engine
   input  wire logic                 i_conv_valid,
   input  wire adcrh_pkg::adcrh_word_t i_conv_raw,
   input  wire logic                 i_cal_done,
   input  wire adcrh_pkg::adcrh_word_t i_cal_offset,
   input  wire adcrh_pkg::adcrh_word_t i_cal_pos,
   input  wire adcrh_pkg::adcrh_word_t i_cal_neg,
   // outputs
   output logic                      o_result_ready_n,
   output logic [7:0]                o_rd_byte,
   output adcrh_pkg::adcrh_word_t    o_control,
   output logic                      o_cal_start,
   output logic                      o_filter_halt,
   output logic                      o_mod_clk_en,
   output logic                      o_start_late,
   output logic                      o_finish_late
);
   import adcrh_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [1:0]  sclk_sync_reg;     // two-stage pin synchroniser
   logic        sclk_prev_reg;     // previous synced level
   adcrh_word_t ctl_reg;           // control register
   adcrh_word_t off_reg;           // offset correction
   adcrh_word_t pos_reg;           // positive slope coefficient
   adcrh_word_t neg_reg;           // negative slope coefficient
   adcrh_word_t out_reg;           // data output register
   adcrh_word_t buf_reg;           // holding buffer
   logic        out_valid_reg;     // unread word in output
   logic        buf_full_reg;      // holding buffer occupied
   logic        reading_reg;       // read of output under way
   logic        cal_busy_reg;      // calibration running
   logic        cal_start_reg;     // calibration start pulse
   logic        result_ready_n_n_reg;        // ready line
   logic [2:0]  hi_cnt_reg;        // min high time count
   logic [21:0] win_cnt_reg;       // cycles since ready fell
   logic        win_run_reg;       // window counter running
   logic        start_late_reg;    // read began late
   logic        finish_late_reg;   // read ended late
   logic [7:0]  rd_byte_reg;       // read byte

   // ----------------------------------------
   // combinational helpers
   // ----------------------------------------
   logic        sclk_rise;         // synced serial clock edge
   logic [1:0]  phys_byte;         // byte after order mapping
   logic        ctl_wr;            // control byte write
   logic        upper_wr;          // write to byte 2 or 1
   logic        standby;           // standby bit
   logic        cal_mode;          // mode field is a calibration mode
   logic        block_ready;       // ready forced high
   logic [21:0] period;            // output rate period
   logic [21:0] start_lim;         // read start limit
   logic [21:0] finish_lim;        // read finish limit
   adcrh_word_t corr_word;         // corrected conversion
   adcrh_word_t ctl_wr_val;        // control after write

   // byte lane replace within a word
   function automatic adcrh_word_t put_byte(input adcrh_word_t w, input logic [1:0] b,
                                            input logic [7:0] d);
      adcrh_word_t r;
      r = w;
      if (b == 2'h0)
         r[7:0] = d;
      else if (b == 2'h1)
         r[15:8] = d;
      else
         r[23:16] = d;
      return r;
   endfunction

   // byte lane pick from a word
   function automatic logic [7:0] get_byte(input adcrh_word_t w, input logic [1:0] b);
      logic [7:0] r;
      r = w[23:16];
      if (b == 2'h0)
         r = w[7:0];
      else if (b == 2'h1)
         r = w[15:8];
      return r;
   endfunction

   // offset removal then slope scaling
   function automatic adcrh_word_t correct(input adcrh_word_t raw, input adcrh_word_t off,
                                           input adcrh_word_t pos, input adcrh_word_t neg);
      logic signed [24:0] diff;
      logic signed [49:0] prod;
      adcrh_word_t        coef;
      diff = $signed({1'b0, raw}) - $signed({1'b0, off});
      coef = diff[24] ? neg : pos;
      prod = diff * $signed({2'b00, coef});
      return prod[`ADCRH_GAIN_SHIFT +: 24];
   endfunction

   always_comb
   begin
      sclk_rise   = sclk_sync_reg[1] & ~sclk_prev_reg;
      // ascending when set, descending when clear [RULE_16]
      phys_byte   = ctl_reg[`ADCRH_CTL_BD] ? i_byte_idx : 2'h2 - i_byte_idx;
      ctl_wr      = i_wr & (i_reg_sel == ADCRH_SEL_CTL);
      upper_wr    = ctl_wr & (phys_byte != 2'h0);                      // [RULE_08] [RULE_09]
      ctl_wr_val  = put_byte(ctl_reg, phys_byte, i_wr_data);
      standby     = ctl_reg[`ADCRH_CTL_SB];
      cal_mode    = (ctl_wr_val[`ADCRH_CTL_MD_HI:`ADCRH_CTL_MD_LO] >= `ADCRH_CAL_MD_MIN) &&
                    (ctl_wr_val[`ADCRH_CTL_MD_HI:`ADCRH_CTL_MD_LO] <= `ADCRH_CAL_MD_MAX);
      block_ready = standby | cal_busy_reg | cal_start_reg | upper_wr;
      // period in oscillator cycles from decimation code [RULE_17]
      period      = 22'(ctl_reg[`ADCRH_CTL_FP_HI:`ADCRH_CTL_FP_LO]) * 22'(`ADCRH_OSC_PER_CODE);
      start_lim   = period - 22'(`ADCRH_START_MARGIN);
      finish_lim  = 22'(period << 1) - 22'(`ADCRH_FINISH_MARGIN);
      corr_word   = correct(i_conv_raw, off_reg, pos_reg, neg_reg);    // [RULE_12]
   end

   // ----------------------------------------
   // serial clock synchroniser
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         sclk_sync_reg <= 2'h0;
         sclk_prev_reg <= 1'b0;
      end
      else
      begin
         sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
         sclk_prev_reg <= sclk_sync_reg[1];
      end
   end

   // ----------------------------------------
   // control register and calibration start
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         ctl_reg       <= `ADCRH_CTL_RESET;
         cal_start_reg <= 1'b1;            // self calibration starts at reset, though the reset mode field is 0
         cal_busy_reg  <= 1'b0;
      end
      else
      begin
         cal_start_reg <= 1'b0;
         if (ctl_wr)
            ctl_reg <= ctl_wr_val;
         // upper byte write selecting a calibration mode restarts calibration [RULE_08]
         if (upper_wr && cal_mode)
            cal_start_reg <= 1'b1;
         if (cal_start_reg)
            cal_busy_reg <= 1'b1;
         else if (i_cal_done)
            cal_busy_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // calibration coefficient registers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         off_reg <= `ADCRH_OFF_RESET;
         pos_reg <= `ADCRH_POS_RESET;
         neg_reg <= `ADCRH_NEG_RESET;
      end
      else if (i_cal_done)
      begin
         // self-cal results after reset or restart [RULE_11] [RULE_13] [RULE_14]
         off_reg <= i_cal_offset;
         pos_reg <= i_cal_pos;
         neg_reg <= i_cal_neg;
      end
      else if (i_wr)
      begin
         // host byte writes in chosen order [RULE_16]
         if (i_reg_sel == ADCRH_SEL_OFF)
            off_reg <= put_byte(off_reg, phys_byte, i_wr_data);
         else if (i_reg_sel == ADCRH_SEL_POS)
            pos_reg <= put_byte(pos_reg, phys_byte, i_wr_data);
         else if (i_reg_sel == ADCRH_SEL_NEG)
            neg_reg <= put_byte(neg_reg, phys_byte, i_wr_data);
      end
   end

   // ----------------------------------------
   // output register, buffer and read tracking
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         out_reg       <= 24'h000000;
         buf_reg       <= 24'h000000;
         out_valid_reg <= 1'b0;
         buf_full_reg  <= 1'b0;
         reading_reg   <= 1'b0;
      end
      else if (standby || upper_wr)
      begin
         // pending words dropped on halt or reprogram
         out_valid_reg <= 1'b0;
         buf_full_reg  <= 1'b0;
         reading_reg   <= 1'b0;
      end
      else
      begin
         // first serial edge of a data read marks its start
         if (i_data_rd_active && sclk_rise && out_valid_reg)
            reading_reg <= 1'b1;
         if (i_rd_done && reading_reg)
         begin
            reading_reg <= 1'b0;
            // buffered word moves up at read end [RULE_07]
            if (buf_full_reg)
            begin
               out_reg      <= buf_reg;
               buf_full_reg <= 1'b0;
            end
            else
               out_valid_reg <= 1'b0;                                  // [RULE_06]
         end
         if (i_conv_valid && !cal_busy_reg)
         begin
            if (reading_reg && !i_rd_done)
            begin
               // word under read kept, newest held aside [RULE_02] [RULE_03] [RULE_05]
               buf_reg      <= corr_word;
               buf_full_reg <= 1'b1;
            end
            else if (reading_reg && i_rd_done && buf_full_reg)
            begin
               buf_reg      <= corr_word;                              // buffer refills as it empties
               buf_full_reg <= 1'b1;                                   // new word beats the move-up clear [RULE_03]
            end
            else
            begin
               // unread word may be replaced when read starts late [RULE_04]
               out_reg       <= corr_word;
               out_valid_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // ready line with minimum high time
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         result_ready_n_n_reg <= 1'b1;
         hi_cnt_reg <= 3'(`ADCRH_RESULT_READY_N_MIN_HIGH_CYC);
      end
      else if (block_ready || (i_rd_done && reading_reg))
      begin
         // forced high: standby, calibration, upper write, read end [RULE_06] [RULE_08] [RULE_15]
         result_ready_n_n_reg <= 1'b1;
         hi_cnt_reg <= 3'(`ADCRH_RESULT_READY_N_MIN_HIGH_CYC);
      end
      else if (result_ready_n_n_reg)
      begin
         if (hi_cnt_reg != 3'h0)
            hi_cnt_reg <= hi_cnt_reg - 3'h1;
         else if (out_valid_reg)
            result_ready_n_n_reg <= 1'b0;                                        // [RULE_01] [RULE_07]
      end
      else if (!out_valid_reg)
      begin
         result_ready_n_n_reg <= 1'b1;
         hi_cnt_reg <= 3'(`ADCRH_RESULT_READY_N_MIN_HIGH_CYC);
      end
   end

   // ----------------------------------------
   // read start and finish windows
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         win_cnt_reg     <= 22'h000000;
         win_run_reg     <= 1'b0;
         start_late_reg  <= 1'b0;
         finish_late_reg <= 1'b0;
      end
      else if (!result_ready_n_n_reg && !win_run_reg)
      begin
         // window opens at ready falling [RULE_17]
         win_cnt_reg     <= 22'h000000;
         win_run_reg     <= 1'b1;
         start_late_reg  <= 1'b0;
         finish_late_reg <= 1'b0;
      end
      else if (win_run_reg)
      begin
         if (win_cnt_reg != 22'h3FFFFF)
            win_cnt_reg <= win_cnt_reg + 22'h000001;
         // start not seen before limit [RULE_04]
         if (!reading_reg && result_ready_n_n_reg == 1'b0 && win_cnt_reg >= start_lim)
            start_late_reg <= 1'b1;
         // finish not seen before limit [RULE_05]
         if (win_cnt_reg >= finish_lim)
            finish_late_reg <= 1'b1;
         if (result_ready_n_n_reg)
            win_run_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // read data byte
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         rd_byte_reg <= 8'h00;
      else if (i_reg_sel == ADCRH_SEL_DATA)
         rd_byte_reg <= get_byte(out_reg, phys_byte);                  // [RULE_16]
      else if (i_reg_sel == ADCRH_SEL_CTL)
         rd_byte_reg <= get_byte(ctl_reg, phys_byte);
      else if (i_reg_sel == ADCRH_SEL_OFF)
         rd_byte_reg <= get_byte(off_reg, phys_byte);
      else if (i_reg_sel == ADCRH_SEL_POS)
         rd_byte_reg <= get_byte(pos_reg, phys_byte);
      else
         rd_byte_reg <= get_byte(neg_reg, phys_byte);
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_result_ready_n = result_ready_n_n_reg;
   assign o_rd_byte        = rd_byte_reg;
   assign o_control        = ctl_reg;
   assign o_cal_start      = cal_start_reg;
   assign o_filter_halt    = ctl_reg[`ADCRH_CTL_SB];                   // [RULE_15]
   assign o_mod_clk_en     = ~ctl_reg[`ADCRH_CTL_SB];                  // [RULE_15]
   assign o_start_late     = start_late_reg;
   assign o_finish_late    = finish_late_reg;

endmodule // adcrh_result_cal
`default_nettype wire

/* File: testbench/adcrh_result_cal_props.sv */
// checker watching the ports of the result hand-off block
`default_nettype none
module adcrh_result_cal_props import adcrh_pkg::*;
(
   // clock, reset, register access and conversion strobe
   input wire logic                   i_ref_clk,
   input wire logic                   i_rst_b,
   input wire adcrh_pkg::adcrh_sel_t  i_reg_sel,
   input wire logic                   i_data_rd_active,
   input wire logic                   i_rd_done,
   input wire logic [1:0]             i_byte_idx,
   input wire logic                   i_wr,
   input wire logic [7:0]             i_wr_data,
   input wire logic                   i_conv_valid,
   // outputs
   input wire logic                   o_result_ready_n,
   input wire logic [7:0]             o_rd_byte,
   input wire adcrh_pkg::adcrh_word_t o_control,
   input wire logic                   o_cal_start,
   input wire logic                   o_filter_halt,
   input wire logic                   o_mod_clk_en
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---
   // helpers
   // ---
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);
   logic [1:0] idx_pos; // control byte the index points at
   logic       ctl_wr;  // write strobe aimed at control
   assign idx_pos = o_control[2] ? i_byte_idx : 2'h2 - i_byte_idx;
   assign ctl_wr  = i_wr && (i_reg_sel == ADCRH_SEL_CTL);
   // ---
   // properties
   // ---
   sequence s_rise; $rose(o_result_ready_n); endsequence
   sequence s_stay_high; o_result_ready_n [*4]; endsequence
   property p_min_high; s_rise |-> s_stay_high; endproperty
   property p_read_clears; i_rd_done && i_data_rd_active && !o_result_ready_n |=> o_result_ready_n; endproperty
   property p_read_kept;
      !o_result_ready_n && i_data_rd_active && i_conv_valid && !i_rd_done && !i_wr |=> !o_result_ready_n;
   endproperty
   property p_upper_wr; ctl_wr && idx_pos != 2'h0 |=> o_result_ready_n; endproperty
   property p_recal; ctl_wr && idx_pos == 2'h1 && i_wr_data[3:1] inside {[1:5]} |-> ##[1:2] o_cal_start; endproperty
   property p_low_wr;
      ctl_wr && idx_pos == 2'h0 && !i_wr_data[3] && !o_result_ready_n && !i_rd_done |=>
         !o_result_ready_n && !o_cal_start;
   endproperty
   property p_standby;
      o_control[3] && $past(o_control[3]) |-> o_result_ready_n && o_filter_halt && !o_mod_clk_en;
   endproperty
   property p_byte_order; i_reg_sel == ADCRH_SEL_CTL |=> o_rd_byte == $past(o_control[8 * idx_pos +: 8]); endproperty
   a_min_high: assert property (p_min_high) else $error("ready high time too short");
   a_read_clears: assert property (p_read_clears) else $error("ready stayed low after read");
   a_read_kept: assert property (p_read_kept) else $error("ready dropped during read");
   a_upper_wr: assert property (p_upper_wr) else $error("upper control write kept ready low");
   a_recal: assert property (p_recal) else $error("no calibration restart");
   a_low_wr: assert property (p_low_wr) else $error("low byte write disturbed ready");
   a_standby: assert property (p_standby) else $error("standby outputs wrong");
   a_byte_order: assert property (p_byte_order) else $error("control byte order wrong");
endmodule // adcrh_result_cal_props
bind adcrh_result_cal adcrh_result_cal_props u_props (.i_ref_clk, .i_rst_b, .i_reg_sel, .i_data_rd_active,
   .i_rd_done, .i_byte_idx, .i_wr, .i_wr_data, .i_conv_valid, .o_result_ready_n, .o_rd_byte, .o_control,
   .o_cal_start, .o_filter_halt, .o_mod_clk_en);
`default_nettype wire

/* File: testbench/adcrh_host_model.sv */
// host model reading and writing registers through the framing side
`default_nettype none
module adcrh_host_model import adcrh_pkg::*;
(
   // clock and returned byte
   input  wire logic              i_ref_clk,
   input  wire logic [7:0]        i_rd_byte,
   // register access
   output logic                   o_sclk,
   output adcrh_pkg::adcrh_sel_t  o_reg_sel,
   output logic                   o_data_rd_active,
   output logic                   o_rd_done,
   output logic [1:0]             o_byte_idx,
   output logic                   o_wr,
   output logic [7:0]             o_wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // link clock stands low outside frames
   initial
   begin
      {o_sclk, o_data_rd_active, o_rd_done, o_wr, o_byte_idx, o_wr_data} = '0;
      o_reg_sel = ADCRH_SEL_DATA;
   end
   // wait edges, then step just past the last one
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #10;
   endtask
   // three byte read, bytes in the order they arrive; 800 ns link clock
   task automatic read_reg(input adcrh_sel_t sel, output adcrh_word_t w);
      o_reg_sel        = sel;
      o_data_rd_active = (sel == ADCRH_SEL_DATA);
      for (int i = 0; i < 3; i++)
      begin
         o_byte_idx = 2'(i);
         o_sclk     = 1'b1;
         tick(4);
         w          = {w[15:0], i_rd_byte};
         o_sclk     = 1'b0;
         tick(4);
      end
      o_rd_done = 1'b1; // read ends right after the third byte
      tick(1);
      o_rd_done        = 1'b0;
      o_data_rd_active = 1'b0;
      o_byte_idx       = ~o_byte_idx; // released index no longer shows last value
      tick(1); // one idle edge before the next request
   endtask
   // single byte write; data line inverted once released
   task automatic write_byte(input adcrh_sel_t sel, input logic [1:0] idx, input logic [7:0] d);
      o_reg_sel  = sel;
      o_byte_idx = idx;
      o_wr_data  = d;
      o_wr       = 1'b1;
      tick(1);
      o_wr      = 1'b0;
      o_wr_data = ~d;
      tick(1);
   endtask
endmodule // adcrh_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the result hand-off and calibration block
`default_nettype none
module testbench import adcrh_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   // ---
   // signals
   // ---
   logic        i_ref_clk = 1'b0, i_rst_b = 1'b0, i_sclk, i_data_rd_active, i_rd_done, i_wr;
   logic        i_conv_valid = 1'b0, i_cal_done = 1'b0, o_result_ready_n, o_cal_start;
   logic        o_filter_halt, o_mod_clk_en, o_start_late, o_finish_late;
   logic [1:0]  i_byte_idx;
   logic [7:0]  i_wr_data, o_rd_byte;
   adcrh_sel_t  i_reg_sel;
   adcrh_word_t i_conv_raw = '0, i_cal_offset = 24'h000010, i_cal_pos = 24'h400000, i_cal_neg = 24'h400000;
   adcrh_word_t o_control, w;
   int          fails = 0, samples_checked = 0, cycles = 0, cal_seen = 0;
   typedef struct { adcrh_word_t raw; adcrh_word_t exp; } adcrh_row_t;
   adcrh_row_t  rows[4] = '{'{24'h000010, 24'h000000}, '{24'h123456, 24'h123446},
                            '{24'h000011, 24'h000001}, '{24'h0A5A5A, 24'h0A5A4A}};
   adcrh_sel_t  coef_sel[3] = '{ADCRH_SEL_OFF, ADCRH_SEL_POS, ADCRH_SEL_NEG};
   adcrh_word_t coef_exp[3] = '{24'h000010, 24'h400000, 24'h400000};
   // ---
   // design, host and clock
   // ---
   adcrh_result_cal DUT (.i_ref_clk, .i_rst_b, .i_sclk, .i_reg_sel, .i_data_rd_active, .i_rd_done, .i_byte_idx,
      .i_wr, .i_wr_data, .i_conv_valid, .i_conv_raw, .i_cal_done, .i_cal_offset, .i_cal_pos, .i_cal_neg,
      .o_result_ready_n, .o_rd_byte, .o_control, .o_cal_start, .o_filter_halt, .o_mod_clk_en, .o_start_late,
      .o_finish_late);
   adcrh_host_model u_host (.i_ref_clk, .i_rd_byte(o_rd_byte), .o_sclk(i_sclk), .o_reg_sel(i_reg_sel),
      .o_data_rd_active(i_data_rd_active), .o_rd_done(i_rd_done), .o_byte_idx(i_byte_idx), .o_wr(i_wr),
      .o_wr_data(i_wr_data));
   always #50 i_ref_clk = ~i_ref_clk;
   // hang guard and calibration pulse counter
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (o_cal_start === 1'b1 && i_rst_b) cal_seen++;
      if (cycles == 40000)
      begin
         fails++;
         end_of_test();
      end
   end
   // ---
   // tasks
   // ---
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #10;
   endtask
   task automatic conv(input adcrh_word_t raw);
      i_conv_raw   = raw;
      i_conv_valid = 1'b1;
      tick(1);
      i_conv_valid = 1'b0;
      i_conv_raw   = ~raw;
   endtask
   task automatic cal();
      i_cal_done = 1'b1;
      tick(1);
      i_cal_done = 1'b0;
   endtask
   task automatic conv_ready(input adcrh_word_t raw);
      conv(raw);
      for (int i = 0; i < 40 && o_result_ready_n !== 1'b0; i++) tick(1);
      check("ready low", o_result_ready_n, 1'b0);
   endtask
   // n conversions land while a read is under way
   task automatic overlap(input int n);
      int hi;
      hi = 0;
      conv_ready(24'h001010);
      fork
         u_host.read_reg(ADCRH_SEL_DATA, w);
         for (int k = 1; k <= n; k++)
         begin
            tick(7);
            conv(24'h001010 + 24'(k) * 24'h001000);
         end
      join
      check("word under read", w, 24'h001000);
      while (o_result_ready_n === 1'b1 && hi < 40)
      begin
         tick(1);
         hi++;
      end
      check("high time", 24'(hi >= 3 && hi < 40), 24'h1);
      u_host.read_reg(ADCRH_SEL_DATA, w);
      check("buffered word", w, 24'(n) * 24'h001000 + 24'h001000);
   endtask
   // ---
   // main sequence
   // ---
   initial
   begin
      tick(11);
      check("reset ready", o_result_ready_n, 1'b1);
      check("reset control", o_control, 24'h014100);
      check("reset flags", {o_start_late, o_finish_late, o_rd_byte}, 24'h0);
      tick(1);
      i_rst_b = 1'b1;
      tick(3);
      check("self cal start", 24'(cal_seen), 24'h1);
      u_host.read_reg(ADCRH_SEL_CTL, w);
      check("control read", w, 24'h014100);
      cal();
      foreach (coef_sel[i])
      begin
         u_host.read_reg(coef_sel[i], w);
         check("coefficient", w, coef_exp[i]);
      end
      foreach (rows[i])
      begin
         conv_ready(rows[i].raw);
         u_host.read_reg(ADCRH_SEL_DATA, w);
         check("data word", w, rows[i].exp);
         check("ready after read", o_result_ready_n, 1'b1);
         check("start flag", o_start_late, 1'b0);
      end
      overlap(1);
      overlap(2);
      conv_ready(24'h000020);
      tick(10200);
      check("late flags", {o_start_late, o_finish_late}, 2'b10);
      tick(8900);
      check("late finish flag", o_finish_late, 1'b1);
      u_host.read_reg(ADCRH_SEL_DATA, w);
      check("late word", w, 24'h000010);
      for (int m = 0; m < 2; m++)
      begin
         conv_ready(24'h000030);
         cal_seen = 0;
         u_host.write_byte(ADCRH_SEL_CTL, 2'h1, m ? 8'h43 : 8'h41);
         check("ready after upper write", o_result_ready_n, 1'b1);
         tick(3);
         check("calibration restart", 24'(cal_seen), 24'(m));
      end
      cal();
      conv_ready(24'h000030);
      cal_seen = 0;
      u_host.write_byte(ADCRH_SEL_CTL, 2'h2, 8'h00);
      tick(3);
      check("low write keeps ready", {o_result_ready_n, 23'(cal_seen)}, 24'h0);
      u_host.write_byte(ADCRH_SEL_CTL, 2'h2, 8'h08);
      tick(1);
      check("standby", {o_result_ready_n, o_filter_halt, o_mod_clk_en}, 24'h6);
      u_host.write_byte(ADCRH_SEL_CTL, 2'h2, 8'h04);
      u_host.read_reg(ADCRH_SEL_CTL, w);
      check("ascending control", w, 24'h044301);
      check("standby off", {o_filter_halt, o_mod_clk_en}, 24'h1);
      // gain change: whole control word rewritten, ascending order
      cal_seen = 0;
      u_host.write_byte(ADCRH_SEL_CTL, 2'h0, 8'h24);
      u_host.write_byte(ADCRH_SEL_CTL, 2'h1, 8'h43);
      u_host.write_byte(ADCRH_SEL_CTL, 2'h2, 8'h01);
      check("full rewrite", {o_result_ready_n, 23'(cal_seen)}, 24'h800002);
      cal();
      u_host.write_byte(ADCRH_SEL_NEG, 2'h0, 8'h5A);
      u_host.read_reg(ADCRH_SEL_NEG, w);
      check("negative coefficient", w, 24'h5A0040);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
